/* rtl/bpmc_pkg.sv */
package bpmc_pkg;
    // register addresses
    localparam logic [7:0] ADDR_MAIN = 8'h00;
    localparam logic [7:0] ADDR_BOOST1 = 8'h21;
    localparam logic [7:0] ADDR_BOOST2 = 8'h22;
    localparam logic [7:0] ADDR_PUMP = 8'h23;
    localparam logic [7:0] ADDR_SW1 = 8'h24;
    localparam logic [7:0] ADDR_SW2 = 8'h25;
    // reset values
    localparam logic [7:0] RST_MAIN = 8'h00;
    localparam logic [7:0] RST_BOOST1 = 8'h00;
    localparam logic [7:0] RST_BOOST2 = 8'h0C;
    localparam logic [7:0] RST_PUMP = 8'h00;
    localparam logic [7:0] RST_SW = 8'h00;
    localparam logic [7:0] READ_NONE = 8'h00;
    // field positions
    localparam int MAIN_PUMP_ON = 2;
    localparam int MAIN_BOOST_ON = 3;
    localparam int B1_FREQ = 0;
    localparam int B1_FB_LSB = 1;
    localparam int B1_TUNE_LSB = 3;
    localparam int B2_GAIN = 0;
    localparam int B2_SKIP = 1;
    localparam int B2_PROT = 2;
    localparam int B2_LOWCUR = 3;
    localparam int B2_AUTOFB = 7;
    localparam int PC_RATIO_LSB = 1;
    localparam int PC_POLICY_LSB = 3;
    localparam int PC_LONGDEB = 5;
    localparam int PC_AUTOON = 6;
    // sink index in the 16-bit assignment vector {switch2, switch1}
    localparam int HV1_IDX = 8;
    localparam int HV2_IDX = 9;
    localparam int HV6_IDX = 15;
    // feedback codes
    localparam logic [1:0] FB_PIN = 2'h0;
    localparam logic [1:0] FB_HV1 = 2'h1;
    localparam logic [1:0] FB_HV2 = 2'h2;
    localparam logic [1:0] FB_HV6 = 2'h3;
    // switching policy codes
    localparam logic [1:0] POL_AUTO_ALL = 2'h0;
    localparam logic [1:0] POL_AUTO_LIM = 2'h1;
    localparam logic [1:0] POL_MANUAL = 2'h2;
    // ratio field codes
    localparam logic [1:0] RATIO_1X = 2'h0;
    localparam logic [1:0] RATIO_15 = 2'h1;
    localparam logic [1:0] RATIO_2X = 2'h2;
    // debounce timing
    localparam int CLK_MHZ = 40;
    localparam int DEB_SHORT_US = 240;
    localparam int DEB_LONG_US = 2000;
    localparam int DEB_SHORT_CYC = DEB_SHORT_US * CLK_MHZ;
    localparam int DEB_LONG_CYC = DEB_LONG_US * CLK_MHZ;
    localparam int DEB_W = 17;

    typedef enum logic [2:0] {
        PUMP_1X = 3'b001,
        PUMP_15 = 3'b010,
        PUMP_2X = 3'b100
    } bpmc_pump_e;

    typedef struct packed {
        logic run;
        logic freqSel;
        logic [1:0] fbSel;
        logic [4:0] tuning;
        logic gainDivider;
        logic skipElevated;
        logic ovpOn;
        logic lowCurrent;
    } bpmc_boost_s;
endpackage

/* rtl/bpmc_fb_pick.sv */
`timescale 1ns/1ps
module bpmc_fb_pick
    import bpmc_pkg::*;
(
    input wire logic [2:0] eligible,
    input wire logic [2:0] lowest,
    output logic [1:0] pick
);
    function automatic logic [1:0] codeOf(input logic [2:0] v);
        if (v[0]) return FB_HV1;
        if (v[1]) return FB_HV2;
        if (v[2]) return FB_HV6;
        return FB_HV1;
    endfunction

    // lowest eligible sink wins, else first eligible, else HV1 when none is eligible, never the pin
    always_comb
    begin
        if ((eligible & lowest) != 3'h0)
            pick = codeOf(eligible & lowest);
        else
            pick = codeOf(eligible);
    end
endmodule // bpmc_fb_pick

/* rtl/bpmc_debounce.sv */
`timescale 1ns/1ps
module bpmc_debounce
    import bpmc_pkg::*;
#(
    parameter logic [DEB_W-1:0] SHORT_CYC = DEB_W'(DEB_SHORT_CYC),
    parameter logic [DEB_W-1:0] LONG_CYC = DEB_W'(DEB_LONG_CYC)
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic active,
    input wire logic start,
    input wire logic longEn,
    input wire logic lowIn,
    output logic fire
);
    logic [DEB_W-1:0] count;
    logic longPending;
    logic [DEB_W-1:0] limit;
    logic [DEB_W-1:0] heldCnt;

    assign limit = longPending ? LONG_CYC : SHORT_CYC;
    assign fire = active && lowIn && (count == limit - DEB_W'(1));

    // low must hold the whole interval, any gap restarts
    always_ff @(posedge mclk)
    begin
        if (rst || !active || start || !lowIn || fire)
            count <= '0;
        else
            count <= count + DEB_W'(1);
    end

    // first interval after turn-on is the long one when asked
    always_ff @(posedge mclk)
    begin
        if (rst || !active)
            longPending <= 1'b0;
        else if (start)
            longPending <= longEn;
        else if (fire)
            longPending <= 1'b0;
    end

    // checker helper: length of the current unbroken low spell
    always_ff @(posedge mclk)
    begin
        if (rst || !active || !lowIn)
            heldCnt <= '0;
        else if (heldCnt != '1)
            heldCnt <= heldCnt + DEB_W'(1);
    end

    debounce_len_a: assert property (@(posedge mclk)
        disable iff (rst)
        fire |-> heldCnt >= (longPending ? LONG_CYC : SHORT_CYC) - 1)
        else $error("debounce fired before the low spell was long enough");
endmodule // bpmc_debounce

/* rtl/bpmc_top.sv */
// Overview of operation
// - boost runs only while enable bit set
// - frequency bit: 0 is 1MHz, 1 500kHz
// - manual feedback field picks pin or sink
// - five-bit tuning current code, 1uA steps
// - gain bit: divider feedback selects one
// - skip bit trades accuracy for ripple
// - over-voltage bit pauses boost above limit
// - low-current bit cuts coil limit third
// - auto feedback picks eligible sinks, HV1 when none eligible
// - pump offers 1:1, 1:1.5, 1:2 ratios
// - full auto steps 1:1 to 1:1.5 to 1:2
// - limited auto never enters 1:2
// - manual policy follows written ratio field
// - low sink voltage steps pump up one
// - strobe high range uses higher threshold
// - debounce 240us, optional first 2000us
// - policy codes: auto, limited, manual, reserved
// - only assigned sinks trigger up-switching
// - pump off sits in 1:1
`timescale 1ns/1ps
module bpmc_top
    import bpmc_pkg::*;
#(
    parameter logic [DEB_W-1:0] SHORT_CYC = DEB_W'(DEB_SHORT_CYC),
    parameter logic [DEB_W-1:0] LONG_CYC = DEB_W'(DEB_LONG_CYC)
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic regWrite,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    input wire logic [15:0] sinkLow,
    input wire logic [15:0] sinkActive,
    input wire logic [2:0] hvLowest,
    input wire logic fbOverVoltage,
    input wire logic strobeHighRange,
    output bpmc_boost_s boostCtl,
    output logic [1:0] pumpRatio,
    output logic flashHighThresh
);
    logic [7:0] mainReg;
    logic [7:0] boost1;
    logic [7:0] boost2;
    logic [7:0] pumpReg;
    logic [6:0] sw1;
    logic [7:0] sw2;
    logic [15:0] assignMask;
    logic [2:0] fbEligible;
    logic [1:0] autoPick;
    logic [1:0] policy;
    logic [1:0] ratioField;
    logic pumpActive;
    logic pumpActiveQ;
    logic pumpStart;
    logic autoMode;
    logic qualLow;
    logic upFire;
    bpmc_pump_e pumpState;
    bpmc_pump_e next_pumpState;
    bpmc_boost_s next_boostCtl;
    logic [7:0] next_rdata;

    function automatic bpmc_pump_e ratioToState(input logic [1:0] r);
        unique case (r)
            RATIO_15: return PUMP_15;
            RATIO_2X: return PUMP_2X;
            default: return PUMP_1X;
        endcase
    endfunction

    function automatic logic [1:0] stateToRatio(input bpmc_pump_e s);
        unique case (s)
            PUMP_15: return RATIO_15;
            PUMP_2X: return RATIO_2X;
            default: return RATIO_1X;
        endcase
    endfunction

    // register writes
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            mainReg <= RST_MAIN;
            boost1 <= RST_BOOST1;
            boost2 <= RST_BOOST2;
            pumpReg <= RST_PUMP;
            sw1 <= RST_SW[6:0];
            sw2 <= RST_SW;
        end
        else if (regWrite)
        begin
            unique case (regAddr)
                ADDR_MAIN: mainReg <= regWdata;
                ADDR_BOOST1: boost1 <= regWdata;
                ADDR_BOOST2: boost2 <= regWdata;
                ADDR_PUMP: pumpReg <= regWdata;
                ADDR_SW1: sw1 <= regWdata[6:0];
                ADDR_SW2: sw2 <= regWdata;
                default: ;
            endcase
        end
    end

    // read mux; ratio field reports the live ratio
    always_comb
    begin
        next_rdata = READ_NONE;
        unique case (regAddr)
            ADDR_MAIN: next_rdata = mainReg;
            ADDR_BOOST1: next_rdata = boost1;
            ADDR_BOOST2: next_rdata = boost2;
            ADDR_PUMP:
            begin
                next_rdata = pumpReg;
                next_rdata[PC_RATIO_LSB +: 2] = stateToRatio(pumpState);
            end
            ADDR_SW1: next_rdata = {1'b0, sw1};
            ADDR_SW2: next_rdata = sw2;
            default: next_rdata = READ_NONE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            regRdata <= READ_NONE;
        else
            regRdata <= next_rdata;
    end

    // pump-side decode
    assign assignMask = {sw2, 1'b0, sw1};
    assign policy = pumpReg[PC_POLICY_LSB +: 2];
    assign ratioField = pumpReg[PC_RATIO_LSB +: 2];
    assign autoMode = (policy == POL_AUTO_ALL) || (policy == POL_AUTO_LIM);
    assign qualLow = autoMode && ((sinkLow & assignMask) != 16'h0000);
    assign pumpActive = mainReg[MAIN_PUMP_ON]
        || (pumpReg[PC_AUTOON] && ((sinkActive & assignMask) != 16'h0000));
    assign pumpStart = pumpActive && !pumpActiveQ;

    // flash sink threshold select follows the strobe range bit
    always_ff @(posedge mclk)
    begin
        if (rst)
            flashHighThresh <= 1'b0;
        else
            flashHighThresh <= strobeHighRange;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            pumpActiveQ <= 1'b0;
        else
            pumpActiveQ <= pumpActive;
    end

    bpmc_debounce #(
        .SHORT_CYC(SHORT_CYC),
        .LONG_CYC(LONG_CYC)
    ) debounce (
        .mclk(mclk),
        .rst(rst),
        .active(pumpActive),
        .start(pumpStart),
        .longEn(pumpReg[PC_LONGDEB]),
        .lowIn(qualLow),
        .fire(upFire)
    );

    // pump ratio selection
    always_comb
    begin
        next_pumpState = pumpState;
        if (!pumpActive)
            next_pumpState = PUMP_1X;
        else if (policy == POL_MANUAL)
            next_pumpState = ratioToState(ratioField);
        else if (!autoMode)
            next_pumpState = PUMP_1X; // reserved policy holds bypass
        else if (pumpStart)
            next_pumpState = PUMP_1X;
        else if (policy == POL_AUTO_LIM && pumpState == PUMP_2X)
            next_pumpState = PUMP_1X;
        else if (upFire)
        begin
            unique case (pumpState)
                PUMP_1X: next_pumpState = PUMP_15;
                PUMP_15: next_pumpState =
                    (policy == POL_AUTO_ALL) ? PUMP_2X : PUMP_15;
                PUMP_2X: next_pumpState = PUMP_2X;
                default: next_pumpState = PUMP_1X;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            pumpState <= PUMP_1X;
        else
            pumpState <= next_pumpState;
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            pumpRatio <= RATIO_1X;
        else
            pumpRatio <= stateToRatio(next_pumpState);
    end

    // auto feedback candidates: enabled and not on the pump
    assign fbEligible = {
        sinkActive[HV6_IDX] && !assignMask[HV6_IDX],
        sinkActive[HV2_IDX] && !assignMask[HV2_IDX],
        sinkActive[HV1_IDX] && !assignMask[HV1_IDX]};

    bpmc_fb_pick fbPick (
        .eligible(fbEligible),
        .lowest(hvLowest),
        .pick(autoPick)
    );

    // converter controls
    always_comb
    begin
        next_boostCtl.run = mainReg[MAIN_BOOST_ON]
            && !(boost2[B2_PROT] && fbOverVoltage);
        next_boostCtl.freqSel = boost1[B1_FREQ];
        next_boostCtl.fbSel = boost2[B2_AUTOFB] ? autoPick
            : boost1[B1_FB_LSB +: 2];
        next_boostCtl.tuning = boost1[B1_TUNE_LSB +: 5];
        next_boostCtl.gainDivider = boost2[B2_GAIN];
        next_boostCtl.skipElevated = boost2[B2_SKIP];
        next_boostCtl.ovpOn = boost2[B2_PROT];
        next_boostCtl.lowCurrent = boost2[B2_LOWCUR];
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            boostCtl <= '0;
        else
            boostCtl <= next_boostCtl;
    end

    boost_off_a: assert property (@(posedge mclk)
        disable iff (rst) !mainReg[MAIN_BOOST_ON] |=> !boostCtl.run)
        else $error("boost running while disabled");

    ovp_pause_a: assert property (@(posedge mclk)
        disable iff (rst)
        mainReg[MAIN_BOOST_ON] && boost2[B2_PROT] && fbOverVoltage
        |=> !boostCtl.run)
        else $error("boost not paused on over-voltage");

    freq_write_a: assert property (@(posedge mclk)
        disable iff (rst) regWrite && regAddr == ADDR_BOOST1
        |=> ##1 boostCtl.freqSel == $past(regWdata[B1_FREQ], 2))
        else $error("frequency select not applied");

    fb_manual_a: assert property (@(posedge mclk)
        disable iff (rst) !boost2[B2_AUTOFB]
        |=> boostCtl.fbSel == $past(boost1[B1_FB_LSB +: 2]))
        else $error("manual feedback select not applied");

    // written converter fields reach the outputs two edges on
    tuning_write_a: assert property (@(posedge mclk)
        disable iff (rst) regWrite && regAddr == ADDR_BOOST1
        |=> ##1 boostCtl.tuning == $past(regWdata[B1_TUNE_LSB +: 5], 2))
        else $error("tuning code not applied");
    gain_write_a: assert property (@(posedge mclk)
        disable iff (rst) regWrite && regAddr == ADDR_BOOST2
        |=> ##1 boostCtl.gainDivider == $past(regWdata[B2_GAIN], 2))
        else $error("gain select not applied");
    skip_write_a: assert property (@(posedge mclk)
        disable iff (rst) regWrite && regAddr == ADDR_BOOST2
        |=> ##1 boostCtl.skipElevated == $past(regWdata[B2_SKIP], 2))
        else $error("skip mode select not applied");
    lowcur_write_a: assert property (@(posedge mclk)
        disable iff (rst) regWrite && regAddr == ADDR_BOOST2
        |=> ##1 boostCtl.lowCurrent == $past(regWdata[B2_LOWCUR], 2))
        else $error("coil limit select not applied");

    auto_fb_a: assert property (@(posedge mclk)
        disable iff (rst) boost2[B2_AUTOFB] |=> boostCtl.fbSel != FB_PIN)
        else $error("auto feedback chose the pin");

    pump_off_a: assert property (@(posedge mclk)
        disable iff (rst)
        !pumpActive |=> pumpState == PUMP_1X && pumpRatio == RATIO_1X)
        else $error("pump not in bypass when off");

    limit_no2x_a: assert property (@(posedge mclk)
        disable iff (rst)
        $past(policy) == POL_AUTO_LIM && policy == POL_AUTO_LIM
        |-> pumpState != PUMP_2X)
        else $error("limited policy reached top ratio");

    lim_hold_a: assert property (@(posedge mclk)
        disable iff (rst) upFire && !pumpStart && policy == POL_AUTO_LIM
        && pumpState == PUMP_15 |=> pumpState == PUMP_15)
        else $error("limited policy stepped past middle ratio");

    manual_ratio_a: assert property (@(posedge mclk)
        disable iff (rst)
        pumpActive && policy == POL_MANUAL && ratioField != 2'h3
        |=> pumpRatio == $past(ratioField))
        else $error("manual ratio not followed");

    reserved_pol_a: assert property (@(posedge mclk)
        disable iff (rst) !autoMode && policy != POL_MANUAL
        |=> pumpState == PUMP_1X)
        else $error("reserved policy left bypass");

    step_up_a: assert property (@(posedge mclk)
        disable iff (rst)
        upFire && autoMode && !pumpStart && pumpState == PUMP_1X
        |=> pumpState == PUMP_15)
        else $error("no step up after debounce");

    full_2x_a: assert property (@(posedge mclk)
        disable iff (rst) upFire && !pumpStart && policy == POL_AUTO_ALL
        && pumpState == PUMP_15 |=> pumpState == PUMP_2X)
        else $error("full auto did not reach top ratio");

    top_hold_a: assert property (@(posedge mclk)
        disable iff (rst) upFire && pumpActive && policy == POL_AUTO_ALL
        && pumpState == PUMP_2X |=> pumpState == PUMP_2X)
        else $error("top ratio left on low");

    gap_restart_a: assert property (@(posedge mclk)
        disable iff (rst) !qualLow |=> !upFire)
        else $error("up-switch without persistent low");

    unassigned_a: assert property (@(posedge mclk)
        disable iff (rst) (sinkLow & assignMask) == 16'h0000 |=> !upFire)
        else $error("unassigned sink caused up-switch");

    flash_thresh_a: assert property (@(posedge mclk)
        disable iff (rst) flashHighThresh != strobeHighRange
        |=> flashHighThresh == $past(strobeHighRange))
        else $error("flash threshold select not followed");

    reach_2x_c: cover property (@(posedge mclk) disable iff (rst)
        pumpState == PUMP_15 ##1 pumpState == PUMP_2X);
    lim_15_c: cover property (@(posedge mclk) disable iff (rst)
        policy == POL_AUTO_LIM && pumpState == PUMP_15);
    auto_six_c: cover property (@(posedge mclk) disable iff (rst)
        boost2[B2_AUTOFB] && boostCtl.fbSel == FB_HV6);
    ovp_c: cover property (@(posedge mclk) disable iff (rst)
        mainReg[MAIN_BOOST_ON] && !boostCtl.run);
endmodule // bpmc_top

/* verif/bpmc_led_model.sv */
`timescale 1ns/1ps
// led strings and boost feedback network seen by the control block
module bpmc_led_model
    import bpmc_pkg::*;
(
    input wire logic mclk,
    input wire logic [1:0] pumpRatio,
    input wire logic [15:0] enSinks,
    input wire logic [1:0] needRatio,
    input wire logic [2:0] lowestIn,
    input wire logic overVolt,
    output logic [15:0] sinkLow,
    output logic [15:0] sinkActive,
    output logic [2:0] hvLowest,
    output logic fbOverVoltage
);
    // enabled sinks lose headroom while the pump ratio is too low
    always_ff @(posedge mclk)
    begin
        sinkLow <= (pumpRatio < needRatio) ? enSinks : 16'h0000;
    end
    // enables and analog comparators pass straight through
    assign sinkActive = enSinks;
    assign hvLowest = lowestIn;
    assign fbOverVoltage = overVolt;
endmodule // bpmc_led_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb
    import bpmc_pkg::*;
;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic regWrite = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic [15:0] enSinks = 16'h0000;
    logic [1:0] needRatio = 2'h0;
    logic [2:0] lowestIn = 3'h1;
    logic overVolt = 1'b0;
    logic strobeHighRange = 1'b0;
    logic [7:0] regRdata;
    logic [15:0] sinkLow;
    logic [15:0] sinkActive;
    logic [2:0] hvLowest;
    logic fbOverVoltage;
    bpmc_boost_s boostCtl;
    bpmc_boost_s expCtl;
    logic [1:0] pumpRatio;
    logic flashHighThresh;
    int errorCnt = 0;
    int nTests = 0;

    // 40 MHz clock
    always #12.5 mclk = ~mclk;

    // short debounce counts keep the run brief
    bpmc_top #(
        .SHORT_CYC(17'h00008),
        .LONG_CYC(17'h00014)
    ) u_dut (
        .mclk(mclk),
        .rst(rst),
        .regWrite(regWrite),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regRdata(regRdata),
        .sinkLow(sinkLow),
        .sinkActive(sinkActive),
        .hvLowest(hvLowest),
        .fbOverVoltage(fbOverVoltage),
        .strobeHighRange(strobeHighRange),
        .boostCtl(boostCtl),
        .pumpRatio(pumpRatio),
        .flashHighThresh(flashHighThresh)
    );

    bpmc_led_model u_model (
        .mclk(mclk),
        .pumpRatio(pumpRatio),
        .enSinks(enSinks),
        .needRatio(needRatio),
        .lowestIn(lowestIn),
        .overVolt(overVolt),
        .sinkLow(sinkLow),
        .sinkActive(sinkActive),
        .hvLowest(hvLowest),
        .fbOverVoltage(fbOverVoltage)
    );

    task automatic bad(string m);
        errorCnt++;
        $display("unexpected at %0t: %s", $time, m);
    endtask

    task automatic cmp(logic [15:0] got, logic [15:0] want, string m);
        nTests++;
        if (got !== want)
        begin
            bad(m);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge mclk);
    endtask

    // one register write, strobe high for a single cycle
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    // read data is registered one edge after the address
    task automatic rd(logic [7:0] a, logic [7:0] want);
        @(posedge mclk);
        regAddr <= a;
        tick(1);
        @(negedge mclk);
        cmp(16'(regRdata), 16'(want), "register readback");
    endtask

    task automatic cmpBoost();
        tick(1);
        @(negedge mclk);
        nTests++;
        if (boostCtl !== expCtl)
        begin
            bad("boost control outputs");
        end
    endtask

    // waits up to n cycles for the ratio, then compares
    task automatic waitRatio(logic [1:0] want, int n);
        @(negedge mclk);
        for (int i = 0; i < n && pumpRatio !== want; i++)
        begin
            @(negedge mclk);
        end
        cmp(16'(pumpRatio), 16'(want), "pump ratio");
    endtask

    task automatic pumpOn(logic [7:0] cfg);
        wr(ADDR_PUMP, cfg);
        wr(ADDR_MAIN, 8'h04);
    endtask

    task automatic pumpOff();
        wr(ADDR_MAIN, 8'h00);
        waitRatio(RATIO_1X, 4);
    endtask

    task automatic testReset();
        rd(ADDR_MAIN, RST_MAIN);
        rd(ADDR_BOOST1, RST_BOOST1);
        rd(ADDR_BOOST2, RST_BOOST2);
        expCtl = '0;
        expCtl.ovpOn = 1'b1;
        expCtl.lowCurrent = 1'b1;
        cmpBoost();
        wr(8'h30, 8'hFF);
        rd(8'h30, READ_NONE);
        waitRatio(RATIO_1X, 0);
    endtask

    task automatic testBoost();
        wr(ADDR_MAIN, 8'h08);
        wr(ADDR_BOOST2, 8'h03);
        expCtl = '0;
        expCtl.run = 1'b1;
        expCtl.gainDivider = 1'b1;
        expCtl.skipElevated = 1'b1;
        expCtl.freqSel = 1'b1;
        expCtl.tuning = 5'h1F;
        for (int f = 0; f < 4; f++)
        begin
            wr(ADDR_BOOST1, {5'h1F, 2'(f), 1'b1});
            expCtl.fbSel = 2'(f);
            cmpBoost();
        end
        @(posedge mclk);
        overVolt <= 1'b1;
        cmpBoost();
        wr(ADDR_BOOST2, 8'h04);
        expCtl.gainDivider = 1'b0;
        expCtl.skipElevated = 1'b0;
        expCtl.ovpOn = 1'b1;
        expCtl.run = 1'b0;
        cmpBoost();
        @(posedge mclk);
        overVolt <= 1'b0;
        expCtl.run = 1'b1;
        cmpBoost();
        wr(ADDR_BOOST1, 8'h00);
        expCtl.freqSel = 1'b0;
        expCtl.tuning = 5'h00;
        expCtl.fbSel = FB_PIN;
        cmpBoost();
        wr(ADDR_MAIN, 8'h00);
        expCtl.run = 1'b0;
        cmpBoost();
    endtask

    task automatic testAutoFb();
        wr(ADDR_BOOST2, 8'h80);
        @(posedge mclk);
        enSinks <= 16'h8200;
        lowestIn <= 3'h4;
        expCtl.ovpOn = 1'b0;
        expCtl.fbSel = FB_HV6;
        cmpBoost();
        wr(ADDR_SW2, 8'h80);
        expCtl.fbSel = FB_HV2;
        cmpBoost();
        @(posedge mclk);
        enSinks <= 16'h0000;
        expCtl.fbSel = FB_HV1;
        cmpBoost();
        wr(ADDR_BOOST2, 8'h0C);
    endtask

    task automatic testAutoAll();
        wr(ADDR_SW2, 8'h01);
        @(posedge mclk);
        enSinks <= 16'h0100;
        needRatio <= 2'h3;
        tick(20);
        waitRatio(RATIO_1X, 0);
        pumpOn(8'h00);
        tick(4);
        waitRatio(RATIO_1X, 0);
        waitRatio(RATIO_15, 20);
        waitRatio(RATIO_2X, 20);
        rd(ADDR_PUMP, 8'h04);
        tick(30);
        waitRatio(RATIO_2X, 0);
        pumpOff();
    endtask

    // low spells broken by a gap must not add up
    task automatic testLimited();
        @(posedge mclk);
        needRatio <= 2'h0;
        pumpOn(8'h08);
        tick(1);
        needRatio <= 2'h3;
        tick(5);
        needRatio <= 2'h0;
        tick(2);
        needRatio <= 2'h3;
        tick(5);
        waitRatio(RATIO_1X, 0);
        waitRatio(RATIO_15, 20);
        tick(40);
        waitRatio(RATIO_15, 0);
        pumpOff();
    endtask

    task automatic testLong();
        pumpOn(8'h20);
        tick(14);
        waitRatio(RATIO_1X, 0);
        waitRatio(RATIO_15, 20);
        waitRatio(RATIO_2X, 12);
        pumpOff();
        wr(ADDR_SW2, 8'h02);
        pumpOn(8'h00);
        tick(30);
        waitRatio(RATIO_1X, 0);
        pumpOff();
    endtask

    // manual ratios pass through 1:1, last entry is the reserved policy
    task automatic testManual();
        logic [7:0] cfg [5] = '{8'h12, 8'h10, 8'h14, 8'h10, 8'h1C};
        logic [1:0] want [5] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h0};
        wr(ADDR_SW2, 8'h01);
        pumpOn(8'h10);
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_PUMP, cfg[i]);
            tick(12);
            waitRatio(want[i], 0);
        end
        pumpOff();
        cmp(16'(flashHighThresh), 16'h0000, "strobe threshold");
        @(posedge mclk);
        strobeHighRange <= 1'b1;
        tick(1);
        @(negedge mclk);
        cmp(16'(flashHighThresh), 16'h0001, "strobe threshold");
    endtask

    task automatic wrapUp();
        $display("comparisons %0d, mismatches %0d", nTests, errorCnt);
        if (errorCnt == 0 && nTests > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // watchdog well beyond the expected run length
    initial
    begin
        repeat (20000) @(posedge mclk);
        bad("watchdog expired");
        wrapUp();
    end

    // main sequence
    initial
    begin
        tick(6);
        rst <= 1'b0;
        testReset();
        $display("reset test done");
        testBoost();
        $display("boost test done");
        testAutoFb();
        $display("auto feedback test done");
        testAutoAll();
        $display("full auto test done");
        testLimited();
        $display("limited auto test done");
        testLong();
        $display("long debounce test done");
        testManual();
        $display("manual test done");
        wrapUp();
    end
endmodule // tb
